// *** design/dgcc_pkg.sv ***
/*
  Package for the gain, chain and calibration control registers.
  Assumes an 8-bit register port with a 5-bit register address.
*/
package dgcc_pkg;
  // Register addresses
  localparam logic [4:0] GAIN_AND_LINE_ID_ADDR = 5'h0D;
  localparam logic [4:0] CHAIN_CONTROL_ADDR = 5'h0E;
  localparam logic [4:0] FINE_GAIN_CONTROL_ADDR = 5'h0F;
  localparam logic [4:0] FILTER_SELECT_ADDR = 5'h10;
  localparam logic [4:0] CALIBRATION_CONTROL_ADDR = 5'h11;
  // Gain register fields
  localparam int VARIANT_BIT = 6;
  localparam int REVISION_LSB = 2;
  localparam int COARSE_RX_BIT = 1;
  localparam int COARSE_TX_BIT = 0;
  // Chain control fields
  localparam int SLAVE_COUNT_LSB = 5;
  localparam int SLAVE_SELECT_LSB = 3;
  localparam int SYNC_SPACING_BIT = 2;
  localparam int RING_POLARITY_BIT = 1;
  localparam int CHAIN_ENABLE_BIT = 0;
  // Fine gain fields
  localparam int TX_MUTE_BIT = 7;
  localparam int FINE_TX_LSB = 4;
  localparam int RX_MUTE_BIT = 3;
  localparam int FINE_RX_LSB = 0;
  // Filter and calibration fields
  localparam int FILTER_ENABLE_BIT = 4;
  localparam int MANUAL_CAL_BIT = 6;
  localparam int AUTO_CAL_DIS_BIT = 5;
  // Reset values and fixed patterns
  localparam logic [7:0] CHAIN_RESET_MODE01 = 8'h02;
  localparam logic [7:0] CHAIN_RESET_MODE2 = 8'h3F;
  localparam logic [7:0] FINE_GAIN_RESET = 8'h00;
  localparam logic [1:0] COARSE_GAIN_RESET = 2'h0;
  localparam logic [7:0] FILTER_RESET = 8'h08;
  localparam logic [3:0] FILTER_LOW_FIXED = 4'h8;
  localparam logic [1:0] CAL_RESET = 2'h0;
  localparam logic [1:0] SERIAL_MODE2 = 2'h2;
  // Frame sync spacing in serial bit clocks
  localparam logic [5:0] SYNC_GAP_WIDE = 6'h20;
  localparam logic [5:0] SYNC_GAP_NARROW = 6'h10;

  // Receive data word format on the serial output
  typedef enum logic [1:0] {
    DGCC_FMT_16 = 2'b00,
    DGCC_FMT_RSVD = 2'b01,
    DGCC_FMT_15_ONE = 2'b10,
    DGCC_FMT_15_ZERO = 2'b11
  } dgcc_fmt_t;

  // Decoded path settings handed to the analog and filter logic
  typedef struct packed {
    logic tx_mute;
    logic [4:0] tx_atten_db;
    logic rx_mute;
    logic [4:0] rx_gain_db;
    logic iir_enable;
  } dgcc_path_t;

  // Decoded chain settings handed to the serial port logic
  typedef struct packed {
    logic chain_enable;
    logic [2:0] slave_count;
    dgcc_fmt_t rx_format;
    logic [5:0] sync_gap;
    logic ring_active_high;
  } dgcc_chain_t;
endpackage

// *** design/dgcc_regs.sv ***
/*
  Registers 0x0D to 0x11: coarse and fine gain, mute, daisy chain, filter
  choice and calibration control, with decoded settings for the datapath.
  Assumes the serial port delivers one-cycle write strobes and a read
  address on the system clock; line-side identity arrives from the link.
*/
module dgcc_regs
  import dgcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Serial mode straps and line-side identity, from pins or the link
  input wire logic [1:0] serial_mode_i,
  input wire logic line_side_variant_flag_i,
  input wire logic [3:0] line_side_revision_i,
  // Register port from the serial control frame
  input wire logic wr_en_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  // Ring detect and delayed sync from the core
  input wire logic ring_detect_i,
  input wire logic delayed_sync_i,
  // Shared pins
  output logic transfer_request_or_ring_pin_o,
  output logic transfer_request_or_ring_pin_oe_o,
  output logic ring_or_delayed_sync_pin_o,
  // Decoded settings
  output dgcc_path_t path_o,
  output dgcc_chain_t chain_o,
  output logic manual_calibration_o,
  output logic auto_calibration_o
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic [1:0] ring_a;
  logic [1:0] ring_b;
  logic mode_seen;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
      ring_a <= 2'h0;
      ring_b <= 2'h0;
    end
    else
    begin
      sync_a <= {serial_mode_i, line_side_variant_flag_i, line_side_revision_i};
      sync_b <= sync_a;
      ring_a <= {ring_detect_i, delayed_sync_i};
      ring_b <= ring_a;
    end
  end

  // Straps are steady around reset, so their two-stage copy is used as is
  wire logic [1:0] serial_mode = sync_b[6:5];

  // The identity word may change on the link side at any time; a bit-wise
  // synchroniser can tear it, so the word is only taken once two
  // consecutive samples agree
  logic [4:0] id_hold;
  logic [4:0] line_id;
  wire logic id_steady = (id_hold == sync_b[4:0]);

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      id_hold <= 5'h00;
      line_id <= 5'h00;
    end
    else
    begin
      id_hold <= sync_b[4:0];
      if (id_steady)
        line_id <= id_hold;
    end
  end

  wire logic line_side_variant_flag = line_id[4];
  wire logic [3:0] line_side_revision = line_id[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [1:0] coarse_gain;
  logic [7:0] chain_control;
  logic [7:0] fine_gain_control;
  logic recursive_filter_enable;
  logic [1:0] cal_bits;

  wire logic wr_gain = wr_en_i && (addr_i == GAIN_AND_LINE_ID_ADDR);
  wire logic wr_chain = wr_en_i && (addr_i == CHAIN_CONTROL_ADDR);
  wire logic wr_fine = wr_en_i && (addr_i == FINE_GAIN_CONTROL_ADDR);
  wire logic wr_filter = wr_en_i && (addr_i == FILTER_SELECT_ADDR);
  wire logic wr_cal = wr_en_i && (addr_i == CALIBRATION_CONTROL_ADDR);

  // The strap is sampled two cycles after release, so the chain register
  // takes its mode-dependent value once the synchronised mode is valid.
  logic [1:0] settle;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      settle <= 2'h0;
    else if (!settle[1])
      settle <= {settle[0], 1'b1};
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_seen <= 1'b0;
    else if (settle[1])
      mode_seen <= 1'b1;
  end

  wire logic [7:0] chain_strap_value =
    (serial_mode == SERIAL_MODE2) ? CHAIN_RESET_MODE2 : CHAIN_RESET_MODE01;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      chain_control <= CHAIN_RESET_MODE01;
    else if (wr_chain)
      chain_control <= wr_data_i;
    else if (settle[1] && !mode_seen)
      chain_control <= chain_strap_value;
  end

  // Only the two gain bits are stored; identity bits are never written
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      coarse_gain <= COARSE_GAIN_RESET;
    else if (wr_gain)
      coarse_gain <= wr_data_i[COARSE_RX_BIT:COARSE_TX_BIT];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fine_gain_control <= FINE_GAIN_RESET;
    else if (wr_fine)
      fine_gain_control <= wr_data_i;
  end

  // Fixed filter bits are not stored; they always read their set pattern
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      recursive_filter_enable <= FILTER_RESET[FILTER_ENABLE_BIT];
    else if (wr_filter)
      recursive_filter_enable <= wr_data_i[FILTER_ENABLE_BIT];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cal_bits <= CAL_RESET;
    else if (wr_cal)
      cal_bits <= wr_data_i[MANUAL_CAL_BIT:AUTO_CAL_DIS_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  wire logic [7:0] gain_read = {1'b0, line_side_variant_flag,
    line_side_revision, coarse_gain};
  wire logic [7:0] filter_read = {3'h0, recursive_filter_enable,
    FILTER_LOW_FIXED};
  wire logic [7:0] cal_read = {1'b0, cal_bits, 5'h00};

  logic [7:0] next_rd_data;
  always_comb
  begin
    unique case (addr_i)
      GAIN_AND_LINE_ID_ADDR: next_rd_data = gain_read;
      CHAIN_CONTROL_ADDR: next_rd_data = chain_control;
      FINE_GAIN_CONTROL_ADDR: next_rd_data = fine_gain_control;
      FILTER_SELECT_ADDR: next_rd_data = filter_read;
      CALIBRATION_CONTROL_ADDR: next_rd_data = cal_read;
      default: next_rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain decode: coarse and fine steps add; software keeps one of them zero
  function automatic logic [4:0] step_db(input logic [2:0] code);
    logic [4:0] db;
    db = 5'h00;
    if (code[2])
      db = 5'h0C;
    else
      db = 5'({code[1:0], 1'b0} + {3'h0, code[1:0]});
    return db;
  endfunction

  wire logic [4:0] fine_tx_db =
    step_db(fine_gain_control[FINE_TX_LSB +: 3]);
  wire logic [4:0] fine_rx_db =
    step_db(fine_gain_control[FINE_RX_LSB +: 3]);
  wire logic [4:0] coarse_tx_db = coarse_gain[COARSE_TX_BIT] ? 5'h03 : 5'h00;
  wire logic [4:0] coarse_rx_db = coarse_gain[COARSE_RX_BIT] ? 5'h06 : 5'h00;

  dgcc_path_t next_path;
  always_comb
  begin
    next_path.tx_mute = fine_gain_control[TX_MUTE_BIT];
    next_path.tx_atten_db = 5'(fine_tx_db + coarse_tx_db);
    next_path.rx_mute = fine_gain_control[RX_MUTE_BIT];
    next_path.rx_gain_db = 5'(fine_rx_db + coarse_rx_db);
    next_path.iir_enable = recursive_filter_enable;
  end

  ////////////////////////////////////////////////////////////////////////
  // Chain decode; with chaining off every other field is masked out
  wire logic chain_enable = chain_control[CHAIN_ENABLE_BIT];

  dgcc_chain_t next_chain;
  always_comb
  begin
    next_chain.chain_enable = chain_enable;
    next_chain.slave_count = chain_enable ?
      chain_control[SLAVE_COUNT_LSB +: 3] : 3'h0;
    next_chain.rx_format = chain_enable ?
      dgcc_fmt_t'(chain_control[SLAVE_SELECT_LSB +: 2]) : DGCC_FMT_16;
    next_chain.sync_gap = (chain_enable && chain_control[SYNC_SPACING_BIT]) ?
      SYNC_GAP_NARROW : SYNC_GAP_WIDE;
    next_chain.ring_active_high = chain_enable &&
      chain_control[RING_POLARITY_BIT];
  end

  // Ring level as driven on the pin: active low unless chaining is on and the polarity bit set
  wire logic ring_level = ring_b[1] ~^ next_chain.ring_active_high;
  // With chaining off the first pin is the transfer request input
  wire logic next_pin1 = chain_enable ? ring_level : 1'b0;
  wire logic next_pin2 = chain_enable ? ring_b[0] : ring_level;

  ////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= next_rd_data;
  end

  // Enable and value change on the same edge, so the pin never drives
  // a stale level for a cycle when chaining is switched on
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      transfer_request_or_ring_pin_o <= 1'b0;
      transfer_request_or_ring_pin_oe_o <= 1'b0;
      ring_or_delayed_sync_pin_o <= 1'b0;
    end
    else
    begin
      transfer_request_or_ring_pin_o <= next_pin1;
      transfer_request_or_ring_pin_oe_o <= chain_enable;
      ring_or_delayed_sync_pin_o <= next_pin2;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      path_o <= '0;
      chain_o <= '0;
      manual_calibration_o <= 1'b0;
      auto_calibration_o <= 1'b0;
    end
    else
    begin
      path_o <= next_path;
      chain_o <= next_chain;
      manual_calibration_o <= cal_bits[1];
      auto_calibration_o <= !cal_bits[0];
    end
  end

endmodule

// *** tb/dgcc_regs_asserts.sv ***
/*
  Port checker for the gain, chain and calibration register block.
  Assumes the bench writes no earlier than the fourth edge after reset.
*/
module dgcc_regs_asserts
  import dgcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic wr_en_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  // Decoded settings
  input wire dgcc_path_t path_o,
  input wire dgcc_chain_t chain_o,
  input wire logic manual_calibration_o,
  input wire logic auto_calibration_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire fine_wr = wr_en_i && addr_i == FINE_GAIN_CONTROL_ADDR;
  wire chain_wr = wr_en_i && addr_i == CHAIN_CONTROL_ADDR && wr_data_i[0];
  wire cal_wr = wr_en_i && addr_i == CALIBRATION_CONTROL_ADDR;
  gain_top_zero_a: assert property (
    addr_i == GAIN_AND_LINE_ID_ADDR |=> !rd_data_o[7]) else $error("gain bit 7 set");
  filter_fixed_a: assert property (
    addr_i == FILTER_SELECT_ADDR |=> rd_data_o[7:5] == 3'h0 && rd_data_o[3:0] == 4'h8)
    else $error("filter fixed bits wrong");
  tx_mute_a: assert property (
    fine_wr |-> ##2 path_o.tx_mute == $past(wr_data_i[7], 2)) else $error("tx mute wrong");
  rx_mute_a: assert property (
    fine_wr |-> ##2 path_o.rx_mute == $past(wr_data_i[3], 2)) else $error("rx mute wrong");
  cal_manual_a: assert property (
    cal_wr |-> ##2 manual_calibration_o == $past(wr_data_i[6], 2)) else $error("manual cal");
  cal_auto_a: assert property (
    cal_wr |-> ##2 auto_calibration_o == !$past(wr_data_i[5], 2)) else $error("auto cal");
  chain_mask_a: assert property (
    !chain_o.chain_enable && $past(arst_n_i, 2) |-> chain_o.slave_count == 3'h0 &&
    chain_o.sync_gap == SYNC_GAP_WIDE && chain_o.rx_format == DGCC_FMT_16)
    else $error("chain not masked");
  chain_gap_a: assert property (
    chain_wr |-> ##2 chain_o.sync_gap == ($past(wr_data_i[2], 2) ? 6'h10 : 6'h20))
    else $error("sync gap wrong");
  chain_count_a: assert property (
    chain_wr |-> ##2 chain_o.slave_count == $past(wr_data_i[7:5], 2)) else $error("slaves");
  cover property (fine_wr);
  cover property (chain_wr);
  cover property (cal_wr && wr_data_i[6]);
endmodule
bind dgcc_regs dgcc_regs_asserts chk_u (.clk_sys_i, .arst_n_i, .wr_en_i, .addr_i,
  .wr_data_i, .rd_data_o, .path_o, .chain_o, .manual_calibration_o, .auto_calibration_o);

// *** tb/dgcc_dsp_model.sv ***
/*
  Modem DSP model issuing register writes and reads.
  Assumes one clock; write strobes last one cycle.
*/
module dgcc_dsp_model
(
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic wr_en_o,
  output logic [4:0] addr_o,
  output logic [7:0] wr_data_o,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    wr_en_o = 1'b0;
    addr_o = 5'h00;
    wr_data_o = 8'h55;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_sys_i);
    wr_en_o <= 1'b0;
    // Idle data shows the inverse so stale values are never mistaken
    wr_data_o <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    repeat (2) @(posedge clk_sys_i);
    d = rd_data_i;
  endtask
endmodule

// *** tb/daa_gain_chain_control_regs_test.sv ***
/*
  Self-checking bench for the gain, chain and calibration registers.
  Assumes a 10 MHz clock and the DSP model as register master.
*/
module daa_gain_chain_control_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dgcc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic variant = 1'b1;
  logic [3:0] rev = 4'hA;
  logic ring = 1'b0;
  logic dsync = 1'b0;
  logic wr_en, pin1, pin1_oe, pin2, manual_calibration, acal;
  logic [4:0] addr;
  logic [7:0] wdata, rd, got;
  dgcc_path_t path;
  dgcc_chain_t chain;
  int n_mismatch = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  dgcc_regs dut_u (.clk_sys_i(clk), .arst_n_i(arst_n), .serial_mode_i(mode),
    .line_side_variant_flag_i(variant), .line_side_revision_i(rev), .wr_en_i(wr_en),
    .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rd), .ring_detect_i(ring),
    .delayed_sync_i(dsync), .transfer_request_or_ring_pin_o(pin1),
    .transfer_request_or_ring_pin_oe_o(pin1_oe), .ring_or_delayed_sync_pin_o(pin2),
    .path_o(path), .chain_o(chain), .manual_calibration_o(manual_calibration), .auto_calibration_o(acal));
  dgcc_dsp_model dsp_u (.clk_sys_i(clk), .wr_en_o(wr_en), .addr_o(addr),
    .wr_data_o(wdata), .rd_data_i(rd));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdchk(input logic [4:0] a, input logic [7:0] e);
    dsp_u.rd(a, got);
    chk(got, e);
  endtask
  task wrs(input logic [4:0] a, input logic [7:0] d);
    dsp_u.wr(a, d);
    repeat (3) @(posedge clk);
  endtask
  task do_reset(input logic [1:0] m);
    mode <= m;
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdchk(CHAIN_CONTROL_ADDR, 8'h02);
    rdchk(FILTER_SELECT_ADDR, 8'h08);
    rdchk(GAIN_AND_LINE_ID_ADDR, 8'h68);
    $display("reset values done");
  endtask
  task t_coarse;
    wrs(GAIN_AND_LINE_ID_ADDR, 8'hFF);
    rdchk(GAIN_AND_LINE_ID_ADDR, 8'h6B);
    chk({3'h0, path.rx_gain_db}, 8'h06);
    chk({3'h0, path.tx_atten_db}, 8'h03);
    variant <= 1'b0;
    rev <= 4'h5;
    repeat (4) @(posedge clk);
    rdchk(GAIN_AND_LINE_ID_ADDR, 8'h17);
    wrs(GAIN_AND_LINE_ID_ADDR, 8'h00);
    $display("coarse gain done");
  endtask
  task t_fine;
    logic [2:0] c;
    logic [7:0] e;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      e = c[2] ? 8'h0C : 8'(3 * i);
      wrs(FINE_GAIN_CONTROL_ADDR, {c[0], c, ~c[0], c});
      chk({3'h0, path.tx_atten_db}, e);
      chk({3'h0, path.rx_gain_db}, e);
      chk({7'h00, path.tx_mute}, {7'h00, c[0]});
      chk({7'h00, path.rx_mute}, {7'h00, ~c[0]});
    end
    $display("fine gain done");
  endtask
  task t_filter;
    wrs(FILTER_SELECT_ADDR, 8'h18);
    chk({7'h00, path.iir_enable}, 8'h01);
    rdchk(FILTER_SELECT_ADDR, 8'h18);
    wrs(FILTER_SELECT_ADDR, 8'h08);
    chk({7'h00, path.iir_enable}, 8'h00);
    $display("filter done");
  endtask
  task t_chain;
    wrs(CHAIN_CONTROL_ADDR, 8'hFE);
    chk({1'h0, chain.slave_count, 1'b0, pin1_oe, chain.rx_format}, 8'h00);
    chk({2'h0, chain.sync_gap}, 8'h20);
    chk({5'h00, chain.chain_enable, chain.ring_active_high, pin2}, 8'h01);
    rdchk(CHAIN_CONTROL_ADDR, 8'hFE);
    ring <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      wrs(CHAIN_CONTROL_ADDR, {3'h5, 2'(s), 3'h7});
      chk({5'h00, chain.slave_count}, 8'h05);
      chk({6'h00, chain.rx_format}, 8'(s));
      chk({2'h0, chain.sync_gap}, 8'h10);
      chk({6'h00, pin1_oe, pin1}, 8'h03);
      chk({5'h00, chain.chain_enable, chain.ring_active_high, pin2}, 8'h06);
    end
    wrs(CHAIN_CONTROL_ADDR, 8'h01);
    chk({2'h0, chain.sync_gap}, 8'h20);
    chk({6'h00, pin1_oe, pin1}, 8'h02);
    ring <= 1'b0;
    dsync <= 1'b1;
    repeat (5) @(posedge clk);
    chk({6'h00, pin1, pin2}, 8'h03);
    $display("chain done");
  endtask
  task t_cal;
    wrs(CALIBRATION_CONTROL_ADDR, 8'hFF);
    rdchk(CALIBRATION_CONTROL_ADDR, 8'h60);
    chk({6'h00, manual_calibration, acal}, 8'h02);
    wrs(CALIBRATION_CONTROL_ADDR, 8'h40);
    chk({6'h00, manual_calibration, acal}, 8'h03);
    wrs(CALIBRATION_CONTROL_ADDR, 8'h20);
    chk({6'h00, manual_calibration, acal}, 8'h00);
    wrs(5'h12, 8'hFF);
    rdchk(5'h12, 8'h00);
    rdchk(CHAIN_CONTROL_ADDR, 8'h01);
    $display("calibration done");
  endtask
  task t_mode2;
    do_reset(2'h2);
    rdchk(CHAIN_CONTROL_ADDR, 8'h3F);
    chk({3'h1, chain.slave_count, chain.rx_format}, 8'h27);
    chk({2'h0, chain.sync_gap}, 8'h10);
    $display("serial mode 2 done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Far beyond the two hundred or so cycles the tests need
    #2000000;
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    do_reset(2'h0);
    t_reset;
    t_coarse;
    t_fine;
    t_filter;
    t_chain;
    t_cal;
    t_mode2;
    end_of_test;
  end
endmodule
